// *** rtl/gnss_date_time_resolver.sv ***
// Date and time resolver: leap-aware civil clock, week resolution,
// time base selection and next-pulse report sequencing.
// Assumes configuration and satellite data arrive synchronous to i_clock.
`timescale 1ns/100ps
module gnss_date_time_resolver #(
    parameter int unsigned SECOND_CYCLES = date_time_pkg::SECOND_CYCLES
) (
    input  wire logic                       i_clock,
    input  wire logic                       i_rst,
    // Backup clock load at power-up.
    input  wire logic                       i_backup_valid,
    input  date_time_pkg::civil_time_t      i_backup_time,
    input  date_time_pkg::civil_date_t      i_backup_date,
    // Satellite data.
    input  wire logic                       i_gps_week_strobe,
    input  wire logic [9:0]                 i_gps_tx_week,
    input  wire logic                       i_other_week_valid,
    input  wire logic [15:0]                i_other_full_week,
    input  wire logic                       i_tow_strobe,
    input  wire logic [19:0]                i_seconds_into_week,
    input  wire logic                       i_utc_params_valid,
    input  wire logic                       i_leap_count_known,
    input  wire logic                       i_leap_add,
    input  wire logic                       i_leap_sub,
    // Configuration.
    input  wire logic                       i_rollover_override,
    input  wire logic [15:0]                i_reference_rollover_week_setting,
    input  date_time_pkg::time_base_t       i_pulse_time_base_select,
    input  date_time_pkg::civil_variant_t   i_civil_time_variant_select,
    input  date_time_pkg::constellations_t  i_enabled,
    // Pulse and event.
    input  wire logic                       i_pulse_due,
    input  wire logic                       i_external_event_input,
    // Outputs.
    output date_time_pkg::civil_time_t      o_civil_time,
    output date_time_pkg::civil_date_t      o_civil_date,
    output logic                            o_time_loaded,
    output logic                            o_fully_resolved,
    output logic [15:0]                     o_full_week,
    output logic [19:0]                     o_seconds_into_week,
    output logic [11:0]                     o_epoch_year,
    output logic                            o_pulse_enable,
    output logic                            o_pulse_out,
    output logic                            o_event_seen,
    output date_time_pkg::time_base_t       o_event_time_base,
    output date_time_pkg::civil_variant_t   o_active_variant,
    output logic                            o_report_valid,
    output date_time_pkg::pulse_report_t    o_next_pulse_time_report
);

    ////////////////////////////////////////////////////////////////////////
    // Shared one-second tick.

    logic [31:0] tick_count_reg;
    logic        sec_tick;

    assign sec_tick = (tick_count_reg == 32'(SECOND_CYCLES - 1));

    // Free-running divider; every slower activity uses sec_tick as enable.
    always_ff @(posedge i_clock) begin
        if (i_rst || sec_tick) begin
            tick_count_reg <= 32'h0000_0000;
        end else begin
            tick_count_reg <= tick_count_reg + 32'h0000_0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers for the event pin.

    logic event_meta_reg;
    logic event_sync_reg;
    logic event_prev_reg;

    // Two flops before any logic looks at the pin.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            event_meta_reg <= 1'b0;
            event_sync_reg <= 1'b0;
            event_prev_reg <= 1'b0;
        end else begin
            event_meta_reg <= i_external_event_input;
            event_sync_reg <= event_meta_reg;
            event_prev_reg <= event_sync_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Civil clock with backup load and leap handling.

    date_time_pkg::civil_time_t time_next;
    logic                       day_wrap;
    logic                       leap_add_pend_reg;
    logic                       leap_sub_pend_reg;

    civil_second_step u_step (
        .i_time     (o_civil_time),
        .i_date     (o_civil_date),
        .i_leap_add (leap_add_pend_reg),
        .i_leap_sub (leap_sub_pend_reg),
        .o_time     (time_next),
        .o_day_wrap (day_wrap)
    );

    // Pending leap announcements live until the next day wrap.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            leap_add_pend_reg <= 1'b0;
            leap_sub_pend_reg <= 1'b0;
        end else if (i_leap_add || i_leap_sub) begin
            leap_add_pend_reg <= i_leap_add;
            leap_sub_pend_reg <= i_leap_sub && !i_leap_add;
        end else if (sec_tick && day_wrap) begin
            leap_add_pend_reg <= 1'b0;
            leap_sub_pend_reg <= 1'b0;
        end
    end

    // The backup clock seeds local time once, before satellite time.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_civil_time  <= '0;
            o_time_loaded <= 1'b0;
        end else if (!o_time_loaded && i_backup_valid) begin
            o_civil_time  <= i_backup_time;
            o_time_loaded <= 1'b1;
        end else if (sec_tick) begin
            o_civil_time  <= time_next;
        end
    end

    // Date only advances at day wrap; month lengths are not modelled as a
    // limitation: only the day counts up and the month never rolls over.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_civil_date <= '{year: date_time_pkg::EPOCH_GPS_YEAR,
                              month: 4'h1, day: 5'h06};
        end else if (!o_time_loaded && i_backup_valid) begin
            o_civil_date <= i_backup_date;
        end else if (sec_tick && day_wrap) begin
            o_civil_date.day <= o_civil_date.day + 5'h01;
        end
    end

    // Civil time counts as resolved only once leap count is known.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_fully_resolved <= 1'b0;
        end else begin
            o_fully_resolved <= i_leap_count_known;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Week resolution.

    logic [15:0] rollover_week;
    logic [15:0] gps_full_week;

    // Built-in reference unless the host overrides it.
    assign rollover_week = i_rollover_override
                         ? i_reference_rollover_week_setting
                         : date_time_pkg::DEFAULT_ROLLOVER_WEEK;

    week_extender #(
        .W (date_time_pkg::FULL_WEEK_BITS)
    ) u_week (
        .i_clock         (i_clock),
        .i_rst           (i_rst),
        .i_tx_week       (i_gps_tx_week),
        .i_rollover_week (rollover_week),
        .o_full_week     (gps_full_week)
    );

    logic gps_week_seen_reg;

    // Other constellations win; 16 bits covers far beyond 1023 weeks.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_full_week       <= 16'h0000;
            gps_week_seen_reg <= 1'b0;
        end else if (i_other_week_valid) begin
            o_full_week       <= i_other_full_week;
        end else begin
            gps_week_seen_reg <= i_gps_week_strobe;
            if (gps_week_seen_reg) begin
                o_full_week <= gps_full_week;
            end
        end
    end

    // Seconds into week restart at Sunday midnight.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_seconds_into_week <= 20'h00000;
        end else if (i_tow_strobe) begin
            o_seconds_into_week <= i_seconds_into_week;
        end else if (sec_tick) begin
            if (o_seconds_into_week ==
                date_time_pkg::SECONDS_PER_WEEK - 20'h00001) begin
                o_seconds_into_week <= 20'h00000;
            end else begin
                o_seconds_into_week <= o_seconds_into_week + 20'h00001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Time base and variant selection.

    date_time_pkg::civil_variant_t auto_variant;

    // Automatic choice by enabled constellation in fixed priority.
    always_comb begin
        if (i_enabled.gps) begin
            auto_variant = date_time_pkg::CIVIL_USNO;
        end else if (i_enabled.glonass) begin
            auto_variant = date_time_pkg::CIVIL_SU;
        end else if (i_enabled.beidou) begin
            auto_variant = date_time_pkg::CIVIL_NTSC;
        end else if (i_enabled.galileo) begin
            auto_variant = date_time_pkg::CIVIL_EU;
        end else if (i_enabled.navic) begin
            auto_variant = date_time_pkg::CIVIL_NPLI;
        end else begin
            auto_variant = date_time_pkg::CIVIL_USNO;
        end
    end

    // Epoch year of the selected satellite base.
    always_comb begin
        unique case (i_pulse_time_base_select)
            date_time_pkg::BASE_GLONASS:
                o_epoch_year = date_time_pkg::EPOCH_GLO_YEAR;
            date_time_pkg::BASE_GALILEO:
                o_epoch_year = date_time_pkg::EPOCH_GAL_YEAR;
            date_time_pkg::BASE_BEIDOU:
                o_epoch_year = date_time_pkg::EPOCH_BDS_YEAR;
            default:
                o_epoch_year = date_time_pkg::EPOCH_GPS_YEAR;
        endcase
    end

    // One selection drives pulse, event input and report; a civil pulse base tags events under GPS.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_active_variant  <= date_time_pkg::CIVIL_USNO;
            o_event_time_base <= date_time_pkg::BASE_GPS;
        end else begin
            o_active_variant <=
                (i_civil_time_variant_select == date_time_pkg::CIVIL_AUTO)
                ? auto_variant : i_civil_time_variant_select;
            o_event_time_base <=
                (i_pulse_time_base_select == date_time_pkg::BASE_CIVIL)
                ? date_time_pkg::BASE_GPS
                : i_pulse_time_base_select;
        end
    end

    // Event edges are tagged under the shared base.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_event_seen <= 1'b0;
        end else begin
            o_event_seen <= event_sync_reg && !event_prev_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pulse gating and next-pulse report.

    logic civil_ready;

    // A civil grid needs conversion data; satellite grids do not.
    assign civil_ready = (i_pulse_time_base_select !=
                          date_time_pkg::BASE_CIVIL) || i_utc_params_valid;

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_pulse_enable <= 1'b0;
            o_pulse_out    <= 1'b0;
        end else begin
            o_pulse_enable <= civil_ready;
            o_pulse_out    <= i_pulse_due && civil_ready;
        end
    end

    // Reports go out once a second and name the coming pulse as seconds plus one, not wrapped at week end.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_report_valid           <= 1'b0;
            o_next_pulse_time_report <= '0;
        end else begin
            o_report_valid <= sec_tick;
            if (sec_tick) begin
                o_next_pulse_time_report.week <= o_full_week;
                o_next_pulse_time_report.seconds_into_week <=
                    o_seconds_into_week + 20'h00001;
                o_next_pulse_time_report.base <= i_pulse_time_base_select;
                o_next_pulse_time_report.variant <= o_active_variant;
                o_next_pulse_time_report.last_before_pulse <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    chk_pulse_gated: assert property (@(posedge i_clock) disable iff (i_rst)
        o_pulse_out |-> o_pulse_enable)
        else $error("Pulse issued before conversion data.");

    chk_report_rate: assert property (@(posedge i_clock) disable iff (i_rst)
        o_report_valid |=> !o_report_valid)
        else $error("Reports closer than one second.");

    chk_civil_base_gps: assert property (@(posedge i_clock)
        disable iff (i_rst)
        $past(i_pulse_time_base_select) == date_time_pkg::BASE_CIVIL
        && !$past(i_rst) |-> o_event_time_base == date_time_pkg::BASE_GPS)
        else $error("Civil output base did not align input to GPS.");

    chk_auto_gps: assert property (@(posedge i_clock) disable iff (i_rst)
        i_enabled.gps && i_civil_time_variant_select ==
        date_time_pkg::CIVIL_AUTO |=>
        o_active_variant == date_time_pkg::CIVIL_USNO)
        else $error("Automatic variant ignored GPS priority.");

    chk_sec_range: assert property (@(posedge i_clock) disable iff (i_rst)
        o_civil_time.second <= date_time_pkg::SEC_LEAP)
        else $error("Seconds beyond leap value.");

    chk_week_floor: assert property (@(posedge i_clock) disable iff (i_rst)
        gps_week_seen_reg && !i_other_week_valid |=>
        o_full_week >= $past(rollover_week, 2))
        else $error("Extended week below reference.");

    chk_other_week: assert property (@(posedge i_clock) disable iff (i_rst)
        i_other_week_valid |=> o_full_week == $past(i_other_full_week))
        else $error("Other constellation week not taken.");

    chk_resolved: assert property (@(posedge i_clock) disable iff (i_rst)
        !i_leap_count_known |=> !o_fully_resolved)
        else $error("Resolved flag set without leap count.");

endmodule : gnss_date_time_resolver

// *** rtl/date_time_pkg.sv ***
// Package for the date and time resolver: shared constants and carriers.
// Assumes a single 100 MHz receiver clock and plain-port configuration.
package date_time_pkg;

    // Clock rate and derived one-second count.
    localparam int unsigned CLOCK_HZ        = 100_000_000;
    localparam int unsigned SECOND_CYCLES   = CLOCK_HZ;

    // Week arithmetic.
    localparam int          TX_WEEK_BITS    = 10;
    localparam int          FULL_WEEK_BITS  = 16;
    localparam logic [15:0] WEEK_MODULUS    = 16'h0400;
    localparam logic [15:0] DEFAULT_ROLLOVER_WEEK = 16'h05F4;
    localparam logic [19:0] SECONDS_PER_WEEK = 20'h93A80;

    // Civil clock limits.
    localparam logic [5:0]  SEC_LAST_NORMAL = 6'h3B;
    localparam logic [5:0]  SEC_LEAP        = 6'h3C;
    localparam logic [5:0]  SEC_NEG_LAST    = 6'h3A;
    localparam logic [5:0]  MIN_LAST        = 6'h3B;
    localparam logic [4:0]  HOUR_LAST       = 5'h17;
    localparam logic [3:0]  MONTH_JUNE      = 4'h6;
    localparam logic [3:0]  MONTH_DEC       = 4'hC;
    localparam logic [4:0]  DAY_JUNE_LAST   = 5'h1E;
    localparam logic [4:0]  DAY_DEC_LAST    = 5'h1F;

    // Constellation epochs as calendar years.
    localparam logic [11:0] EPOCH_GPS_YEAR  = 12'h7BC;
    localparam logic [11:0] EPOCH_GLO_YEAR  = 12'h7CC;
    localparam logic [11:0] EPOCH_GAL_YEAR  = 12'h7CF;
    localparam logic [11:0] EPOCH_BDS_YEAR  = 12'h7D6;

    // Time bases for the pulse grid: civil or one satellite base.
    typedef enum logic [2:0] {
        BASE_CIVIL, BASE_GPS, BASE_GLONASS, BASE_BEIDOU, BASE_GALILEO,
        BASE_NAVIC
    } time_base_t;

    // Civil-time variants; AUTO chooses from enabled constellations.
    typedef enum logic [2:0] {
        CIVIL_AUTO, CIVIL_USNO, CIVIL_SU, CIVIL_NTSC, CIVIL_EU, CIVIL_NPLI
    } civil_variant_t;

    // Enabled constellations.
    typedef struct packed {
        logic gps;
        logic glonass;
        logic beidou;
        logic galileo;
        logic navic;
    } constellations_t;

    // Civil time of day.
    typedef struct packed {
        logic [4:0] hour;
        logic [5:0] minute;
        logic [5:0] second;
    } civil_time_t;

    // Calendar date.
    typedef struct packed {
        logic [11:0] year;
        logic [3:0]  month;
        logic [4:0]  day;
    } civil_date_t;

    // Report for the upcoming pulse.
    typedef struct packed {
        logic [15:0] week;
        logic [19:0] seconds_into_week;
        logic [2:0]  base;
        logic [2:0]  variant;
        logic        last_before_pulse;
    } pulse_report_t;

endpackage : date_time_pkg

// *** rtl/week_extender.sv ***
// Extends the 10-bit transmitted week to a full week number.
// Assumes inputs are steady for one cycle; result is registered.
`timescale 1ns/100ps
module week_extender #(
    parameter int W = 16
) (
    input  wire logic          i_clock,
    input  wire logic          i_rst,
    input  wire logic [9:0]    i_tx_week,
    input  wire logic [W-1:0]  i_rollover_week,
    output logic      [W-1:0]  o_full_week
);

    logic [W-1:0] base_w;
    logic [W-1:0] cand_w;

    // Take the smallest week congruent to the transmitted one that is not
    // below the reference week.
    always_comb begin
        base_w = {i_rollover_week[W-1:10], 10'h000};
        cand_w = base_w | {{(W-10){1'b0}}, i_tx_week};
        if (cand_w < i_rollover_week) begin
            cand_w = W'(cand_w + date_time_pkg::WEEK_MODULUS);
        end
    end

    // Registered result.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_full_week <= '0;
        end else begin
            o_full_week <= cand_w;
        end
    end

endmodule : week_extender

// *** rtl/civil_second_step.sv ***
// Steps civil time by one second, handling leap seconds.
// Assumes the caller supplies the date and a pending leap direction.
`timescale 1ns/100ps
module civil_second_step (
    input  date_time_pkg::civil_time_t i_time,
    input  date_time_pkg::civil_date_t i_date,
    input  wire logic                  i_leap_add,
    input  wire logic                  i_leap_sub,
    output date_time_pkg::civil_time_t o_time,
    output logic                       o_day_wrap
);

    logic leap_minute;

    // A leap only lands at the end of June or December.
    always_comb begin
        leap_minute = (i_time.hour == date_time_pkg::HOUR_LAST) &&
                      (i_time.minute == date_time_pkg::MIN_LAST) &&
                      (((i_date.month == date_time_pkg::MONTH_DEC) &&
                        (i_date.day == date_time_pkg::DAY_DEC_LAST)) ||
                       ((i_date.month == date_time_pkg::MONTH_JUNE) &&
                        (i_date.day == date_time_pkg::DAY_JUNE_LAST)));
    end

    // Next second, with 60 inserted or 59 skipped as required.
    always_comb begin
        logic wrap_min;
        wrap_min = 1'b0;
        o_time   = i_time;
        if (leap_minute && i_leap_add &&
            i_time.second == date_time_pkg::SEC_LAST_NORMAL) begin
            o_time.second = date_time_pkg::SEC_LEAP;
        end else if (leap_minute && i_leap_sub &&
                     i_time.second == date_time_pkg::SEC_NEG_LAST) begin
            wrap_min = 1'b1;
        end else if (i_time.second >= date_time_pkg::SEC_LAST_NORMAL) begin
            wrap_min = 1'b1;
        end else begin
            o_time.second = i_time.second + 6'h01;
        end
        o_day_wrap = 1'b0;
        if (wrap_min) begin
            o_time.second = 6'h00;
            if (i_time.minute == date_time_pkg::MIN_LAST) begin
                o_time.minute = 6'h00;
                if (i_time.hour == date_time_pkg::HOUR_LAST) begin
                    o_time.hour = 5'h00;
                    o_day_wrap  = 1'b1;
                end else begin
                    o_time.hour = i_time.hour + 5'h01;
                end
            end else begin
                o_time.minute = i_time.minute + 6'h01;
            end
        end
    end

endmodule : civil_second_step

// *** verification/host_time_consumer.sv ***
// Host side model: watches civil seconds as a time consumer would.
// Assumes the resolver's registered civil time, sampled each clock.
`timescale 1ns/100ps
module host_time_consumer (
    input  wire logic                  i_clock,
    input  date_time_pkg::civil_time_t i_time,
    output logic                       o_bad
);
    initial o_bad = 1'b0;
    // Seconds 0 to 60 are legal, so minutes of 59 or 61 seconds pass.
    always @(posedge i_clock) begin
        if (i_time.second > 6'h3C) o_bad <= 1'b1;
    end
endmodule : host_time_consumer

// *** verification/gnss_date_time_resolver_bench.sv ***
// Self-checking bench for the date and time resolver.
// Assumes a shortened second of ten clock cycles and the host model.
`timescale 1ns/100ps
module gnss_date_time_resolver_bench;
    import date_time_pkg::*;
    logic i_clock = 1'b0, i_rst = 1'b1, bk_v = 1'b0, wk_s = 1'b0, oth_v = 1'b0;
    logic add_p = 1'b0, sub_p = 1'b0, rov = 1'b0, lck = 1'b0, due = 1'b0;
    logic utc = 1'b0, zero = 1'b0;
    logic [9:0] txw = 10'h000;
    logic [15:0] oth_w = 16'h0000, ref_s = 16'h0000, d_week;
    logic [19:0] zsow = 20'h00000;
    civil_time_t bk_t = '{5'h17, 6'h3B, 6'h39}, d_time;
    civil_date_t bk_d = '{12'h7E4, 4'h6, 5'h1E};
    time_base_t base = BASE_GPS, d_ebase;
    civil_variant_t var_s = CIVIL_AUTO, d_var;
    constellations_t en = 5'h1F;
    logic d_res, d_pout, d_bad;
    logic [11:0] d_epoch;
    int miscompares = 0, tests_run = 0, cycles = 0;
    ////////////////////////////////////////////////////////////////////
    gnss_date_time_resolver #(.SECOND_CYCLES(10)) i_dut (
        .i_clock(i_clock), .i_rst(i_rst), .i_backup_valid(bk_v),
        .i_backup_time(bk_t), .i_backup_date(bk_d),
        .i_gps_week_strobe(wk_s), .i_gps_tx_week(txw),
        .i_other_week_valid(oth_v), .i_other_full_week(oth_w),
        .i_tow_strobe(zero), .i_seconds_into_week(zsow),
        .i_utc_params_valid(utc), .i_leap_count_known(lck),
        .i_leap_add(add_p), .i_leap_sub(sub_p), .i_rollover_override(rov),
        .i_reference_rollover_week_setting(ref_s),
        .i_pulse_time_base_select(base),
        .i_civil_time_variant_select(var_s), .i_enabled(en),
        .i_pulse_due(due), .i_external_event_input(zero),
        .o_civil_time(d_time), .o_civil_date(), .o_time_loaded(),
        .o_fully_resolved(d_res), .o_full_week(d_week),
        .o_seconds_into_week(), .o_epoch_year(d_epoch),
        .o_pulse_enable(), .o_pulse_out(d_pout), .o_event_seen(),
        .o_event_time_base(d_ebase), .o_active_variant(d_var),
        .o_report_valid(), .o_next_pulse_time_report());
    host_time_consumer i_host (.i_clock(i_clock), .i_time(d_time),
        .o_bad(d_bad));
    ////////////////////////////////////////////////////////////////////
    // Clock and a hang guard well above the couple of hundred cycles used.
    always #5 i_clock = ~i_clock;
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            print_verdict();
        end
    end
    task automatic step();
        @(posedge i_clock);
        #1;
    endtask : step
    task automatic check(input string nm, input logic [19:0] e, g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : check
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    task automatic do_reset();
        i_rst = 1'b1;
        bk_v = 1'b0;
        repeat (4) step();
        i_rst = 1'b0;
    endtask : do_reset
    ////////////////////////////////////////////////////////////////////
    // Loads 23:59:57 on the given June day and follows seconds to 00.
    task automatic leap(input logic add, input logic [4:0] day);
        logic [5:0] prev, e;
        int n;
        do_reset();
        bk_d.day = day;
        bk_v = 1'b1;
        add_p = add;
        sub_p = !add;
        step();
        add_p = 1'b0;
        sub_p = 1'b0;
        step();
        step();
        prev = 6'h39;
        while (prev != 6'h00) begin
            n = 0;
            while (d_time.second === prev && n < 40) begin
                step();
                n++;
            end
            if (add && prev == 6'h3B && day == 5'h1E) e = 6'h3C;
            else if (!add && prev == 6'h3A && day == 5'h1E) e = 6'h00;
            else if (prev >= 6'h3B) e = 6'h00;
            else e = prev + 6'h01;
            check("second", e, d_time.second);
            prev = e;
        end
    endtask : leap
    // Extends a transmitted week against the given reference week.
    task automatic week(input logic ov, input logic [15:0] rw, input logic [9:0] tx);
        logic [15:0] e;
        rov = ov;
        ref_s = ov ? rw : 16'h0064;
        txw = tx;
        wk_s = 1'b1;
        step();
        wk_s = 1'b0;
        step();
        step();
        e = {rw[15:10], tx};
        if (e < rw) e = e + WEEK_MODULUS;
        // An unambiguous week from another constellation overrides GPS.
        if (oth_v) e = oth_w;
        check("full_week", e, d_week);
    endtask : week
    ////////////////////////////////////////////////////////////////////
    initial begin
        leap(1'b1, 5'h1E);
        leap(1'b0, 5'h1E);
        leap(1'b1, 5'h1D);
        week(1'b0, DEFAULT_ROLLOVER_WEEK, 10'h1F4);
        week(1'b0, DEFAULT_ROLLOVER_WEEK, 10'h1F3);
        week(1'b0, DEFAULT_ROLLOVER_WEEK, 10'h000);
        week(1'b1, 16'h0064, 10'h005);
        week(1'b1, 16'h0064, 10'h064);
        oth_v = 1'b1;
        oth_w = 16'h0BB8;
        week(1'b1, 16'h0BB8, 10'h000);
        // Auto variant drops to the next constellation as each is disabled.
        for (int i = 0; i < 5; i++) begin
            en = 5'h1F >> i;
            step();
            step();
            check("variant", CIVIL_USNO + i, d_var);
        end
        base = BASE_GLONASS;
        #1 check("epoch", EPOCH_GLO_YEAR, d_epoch);
        base = BASE_BEIDOU;
        #1 check("epoch", EPOCH_BDS_YEAR, d_epoch);
        step();
        check("event_base", BASE_BEIDOU, d_ebase);
        // The pulse is looked at in the cycle after the edge that sampled it.
        base = BASE_CIVIL;
        due = 1'b1;
        step();
        check("pulse_out", 1'b0, d_pout);
        check("event_base", BASE_GPS, d_ebase);
        utc = 1'b1;
        step();
        due = 1'b0;
        check("pulse_out", 1'b1, d_pout);
        check("resolved", 1'b0, d_res);
        lck = 1'b1;
        step();
        step();
        check("resolved", 1'b1, d_res);
        check("host_bad", 1'b0, d_bad);
        print_verdict();
    end
endmodule : gnss_date_time_resolver_bench
